// [design/vrc_pkg.sv]
// Purpose: Shared constants and types for the output-reset, overvoltage and address config block
// Assumes: Word-wide register access by command code, decoded upstream of this block
// Notes: Threshold codes are indexes handed to analog trim, not voltages
package vrc_pkg;
  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] CMD_OPTIONS = 8'hd2;   // Options register command
  localparam logic [7:0] CMD_BUS_ADDR = 8'hd3;  // Bus address register command
  localparam logic [7:0] CMD_STORE_ALL = 8'h15; // Store all user settings
  // ****************************************
  // Field positions
  // ****************************************
  localparam int OPT_DIVIDER_BIT = 4;
  localparam int OPT_RST_HI_BIT = 3;
  localparam int OPT_RST_EN_BIT = 2;
  localparam int OPT_OV_SEL_BIT = 1;
  localparam int OPT_OV_DIS_BIT = 0;
  localparam int ADDR_PRI_LSB = 8;
  localparam int ADDR_PRI_MSB = 14;
  // ****************************************
  // Masks and reset values
  // ****************************************
  localparam logic [15:0] OPT_WR_MASK = 16'h000f;  // Bit 4 is strap-only
  localparam logic [15:0] ADDR_WR_MASK = 16'h7f7f; // Bits 15 and 7 read zero
  localparam logic [6:0] ADDR_RESET = 7'h00;
  // Mantissa codes of the loop-scale register
  localparam logic [3:0] MANT_8 = 4'h8;
  localparam logic [3:0] MANT_4 = 4'h4;
  localparam logic [3:0] MANT_2 = 4'h2;
  localparam logic [3:0] MANT_1 = 4'h1;

  // Live option settings driven to the analog side
  typedef struct packed {
    logic divider_sel;
    logic rst_hi_sel;
    logic rst_en;
    logic ov_sel;
    logic ov_dis;
  } vrc_opt_t;

  // Word transaction from the bus engine
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] data;
  } vrc_req_t;

  // Fixed OV threshold index: 0..3 low set, 4..7 high set, 7 max
  typedef enum logic [1:0] {OV_IDLE, OV_ARMED} vrc_ovst_t;
endpackage

// [design/vrc_reset_ctl.sv]
// Purpose: Output-reset pin handling that requests a move to the boot voltage
// Assumes: Pin level is synchronous to CLK_I and already filtered
// Notes: A level-low pin while enabled holds the boot request high
`timescale 1ns/100ps
module vrc_reset_ctl (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // Control
  input wire logic enable_i,
  input wire logic pin_low_i,
  // Result
  output logic boot_req_o,
  output logic boot_start_o
);
  logic boot_reg;
  logic boot_next;
  logic start_reg;
  logic start_next;

  // Boot request follows the pin only while enabled; start pulses on the rise
  always_comb begin
    boot_next = enable_i & pin_low_i;
    start_next = boot_next & ~boot_reg;
  end

  // Request registers
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      boot_reg <= 1'b0;
      start_reg <= 1'b0;
    end else if (ce_i) begin
      boot_reg <= boot_next;
      start_reg <= start_next;
    end
  end

  assign boot_req_o = boot_reg;
  assign boot_start_o = start_reg;

  // Disabled pin never moves the target
  a_reset_ignored: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && !enable_i) |=> !boot_reg)
    else $error("boot request while reset disabled");
  // Pin already low when enabled starts at once
  a_reset_start: assert property (@(posedge clk_i) disable iff (reset_i)
    (ce_i && enable_i && pin_low_i && !boot_reg) |=> (boot_reg && start_reg))
    else $error("boot start missing");
endmodule

// [design/vrc_config.sv]
// Purpose: Options and bus address registers of a buck controller
// Assumes: Word reads and writes arrive decoded as command plus data
// Notes: Address changes only take effect after store and supply reset
`timescale 1ns/100ps
module vrc_config (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  // Power-up restore from non-volatile memory
  input wire logic RESTORE_I,
  input wire logic [15:0] NVM_OPT_I,
  input wire logic [6:0] NVM_ADDR_I,
  input wire logic DIVIDER_STRAP_I,
  // Register access
  input wire vrc_pkg::vrc_req_t REQ_I,
  output logic [15:0] RDATA_O,
  output logic RVALID_O,
  // Pins and analog side
  input wire logic ADDR_PIN_LOW_I,
  input wire logic [3:0] LOOP_MANT_I,
  output vrc_pkg::vrc_opt_t OPT_O,
  output logic [2:0] OV_THRESH_O,
  output logic OV_FAULT_EN_O,
  output logic BOOT_REQ_O,
  output logic BOOT_START_O,
  output logic [6:0] ACTIVE_ADDR_O,
  output logic [6:0] STORED_ADDR_O
);
  // ****************************************
  // State
  // ****************************************
  vrc_pkg::vrc_opt_t opt_reg, opt_next;
  logic [6:0] addr_reg, addr_next;
  logic [6:0] active_reg, active_next;
  logic [6:0] stored_reg, stored_next;
  logic [15:0] rdata_reg, rdata_next;
  logic rvalid_reg, rvalid_next;
  logic strap_reg, strap_next;
  logic [2:0] ov_reg, ov_next;
  logic wr_opt, wr_addr, do_store;

  // Decode of word transactions
  assign wr_opt = REQ_I.wr && (REQ_I.cmd == vrc_pkg::CMD_OPTIONS);
  assign wr_addr = REQ_I.wr && (REQ_I.cmd == vrc_pkg::CMD_BUS_ADDR);
  assign do_store = REQ_I.wr && (REQ_I.cmd == vrc_pkg::CMD_STORE_ALL);

  // Next register values
  always_comb begin
    opt_next = opt_reg;
    addr_next = addr_reg;
    active_next = active_reg;
    stored_next = stored_reg;
    strap_next = strap_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    if (RESTORE_I) begin
      // Supply reset: restore and take stored address into use
      strap_next = DIVIDER_STRAP_I;
      opt_next.rst_hi_sel = NVM_OPT_I[vrc_pkg::OPT_RST_HI_BIT];
      opt_next.rst_en = NVM_OPT_I[vrc_pkg::OPT_RST_EN_BIT];
      opt_next.ov_sel = NVM_OPT_I[vrc_pkg::OPT_OV_SEL_BIT];
      opt_next.ov_dis = NVM_OPT_I[vrc_pkg::OPT_OV_DIS_BIT];
      addr_next = NVM_ADDR_I;
      stored_next = NVM_ADDR_I;
      active_next = NVM_ADDR_I;
    end else begin
      if (wr_opt) begin
        // Bit 4 and upper bits dropped, low four stored
        opt_next.rst_hi_sel = REQ_I.data[vrc_pkg::OPT_RST_HI_BIT];
        opt_next.rst_en = REQ_I.data[vrc_pkg::OPT_RST_EN_BIT];
        opt_next.ov_sel = REQ_I.data[vrc_pkg::OPT_OV_SEL_BIT];
        opt_next.ov_dis = REQ_I.data[vrc_pkg::OPT_OV_DIS_BIT];
      end
      if (wr_addr) begin
        // Only primary field kept; secondary mirrors it, bits 15 and 7 dropped
        addr_next = REQ_I.data[vrc_pkg::ADDR_PRI_MSB:vrc_pkg::ADDR_PRI_LSB];
      end
      if (do_store) begin
        stored_next = addr_reg;
      end
      if (REQ_I.rd) begin
        rvalid_next = 1'b1;
        case (REQ_I.cmd)
          vrc_pkg::CMD_OPTIONS: begin
            rdata_next = {11'h000, strap_reg, opt_reg.rst_hi_sel, opt_reg.rst_en,
              opt_reg.ov_sel, opt_reg.ov_dis};
          end
          vrc_pkg::CMD_BUS_ADDR: begin
            rdata_next = {1'b0, addr_reg, 1'b0, addr_reg};
          end
          default: begin
            rdata_next = 16'h0000;
          end
        endcase
      end
    end
    opt_next.divider_sel = strap_next;
  end

  // Fixed OV threshold index from mantissa and select bit
  always_comb begin
    case (LOOP_MANT_I)
      vrc_pkg::MANT_8: ov_next = {opt_reg.ov_sel, 2'h0};
      vrc_pkg::MANT_4: ov_next = {opt_reg.ov_sel, 2'h1};
      vrc_pkg::MANT_2: ov_next = {opt_reg.ov_sel, 2'h2};
      vrc_pkg::MANT_1: ov_next = {opt_reg.ov_sel, 2'h3};
      default: ov_next = {opt_reg.ov_sel, 2'h3};
    endcase
  end

  // Register stage
  always_ff @(posedge CLK_I or posedge RESET_I) begin
    if (RESET_I) begin
      opt_reg <= '0;
      addr_reg <= vrc_pkg::ADDR_RESET;
      active_reg <= vrc_pkg::ADDR_RESET;
      stored_reg <= vrc_pkg::ADDR_RESET;
      strap_reg <= 1'b0;
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
      ov_reg <= 3'h0;
    end else if (CE_I) begin
      opt_reg <= opt_next;
      addr_reg <= addr_next;
      active_reg <= active_next;
      stored_reg <= stored_next;
      strap_reg <= strap_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
      ov_reg <= ov_next;
    end
  end

  // Output-reset pin handling
  vrc_reset_ctl u_reset_ctl (
    .clk_i(CLK_I),
    .reset_i(RESET_I),
    .ce_i(CE_I),
    .enable_i(opt_reg.rst_en),
    .pin_low_i(ADDR_PIN_LOW_I),
    .boot_req_o(BOOT_REQ_O),
    .boot_start_o(BOOT_START_O)
  );

  // Outputs
  assign RDATA_O = rdata_reg;
  assign RVALID_O = rvalid_reg;
  assign OPT_O = opt_reg;
  assign OV_THRESH_O = ov_reg;
  assign OV_FAULT_EN_O = ~opt_reg.ov_dis;
  assign ACTIVE_ADDR_O = active_reg;
  assign STORED_ADDR_O = stored_reg;

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_addr_write;
    CE_I && !RESTORE_I && wr_addr;
  endsequence
  sequence s_no_restore_2;
    !RESTORE_I [*2];
  endsequence

  a_addr_not_live: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (s_addr_write ##0 s_no_restore_2) |=> $stable(active_reg))
    else $error("active address changed without supply reset");
  a_addr_restore: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && RESTORE_I) |=> (active_reg == addr_reg))
    else $error("readback address differs from answered address");
  a_addr_readback: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && !RESTORE_I && REQ_I.rd && REQ_I.cmd == vrc_pkg::CMD_BUS_ADDR)
    |=> (RVALID_O && RDATA_O[15] == 1'b0 && RDATA_O[7] == 1'b0))
    else $error("address reserved bits not zero");
  a_addr_mirror: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && !RESTORE_I && REQ_I.rd && REQ_I.cmd == vrc_pkg::CMD_BUS_ADDR)
    |=> (RDATA_O[6:0] == RDATA_O[14:8]))
    else $error("secondary address not mirrored");
  a_strap_read: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && !RESTORE_I && REQ_I.rd && REQ_I.cmd == vrc_pkg::CMD_OPTIONS)
    |=> (RDATA_O[vrc_pkg::OPT_DIVIDER_BIT] == strap_reg))
    else $error("divider bit not strap value");
  a_opt_write: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && !RESTORE_I && wr_opt) |=> (opt_reg.rst_en == $past(REQ_I.data[2])
    && opt_reg.divider_sel == $past(strap_reg)))
    else $error("option write mishandled");
  a_ov_enable: assert property (@(posedge CLK_I) disable iff (RESET_I)
    OV_FAULT_EN_O == !OPT_O.ov_dis)
    else $error("ov fault enable polarity wrong");
  a_ov_thresh: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && LOOP_MANT_I == vrc_pkg::MANT_8) |=> (OV_THRESH_O == {$past(opt_reg.ov_sel), 2'h0}))
    else $error("ov threshold index wrong");
  a_rst_levels: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && !RESTORE_I && wr_opt) |=> (OPT_O.rst_hi_sel == $past(REQ_I.data[3])))
    else $error("reset threshold select not stored");
  // Lowest mantissa picks the top index of the selected set
  a_ov_thresh_top: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && LOOP_MANT_I == vrc_pkg::MANT_1) |=> (OV_THRESH_O == {$past(opt_reg.ov_sel), 2'h3}))
    else $error("ov threshold top index wrong");
  // Enabled pin pulled low raises the boot request next cycle
  a_boot_on_pin: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && opt_reg.rst_en && ADDR_PIN_LOW_I) |=> BOOT_REQ_O)
    else $error("boot request missing on pin low");
  // Store copies the written address, not the live one
  a_store_addr: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && !RESTORE_I && do_store) |=> (STORED_ADDR_O == $past(addr_reg)))
    else $error("stored address wrong");
  // Primary field taken from the write, read-only bits dropped
  a_addr_write_ro: assert property (@(posedge CLK_I) disable iff (RESET_I)
    (CE_I && !RESTORE_I && wr_addr)
    |=> (addr_reg == $past(REQ_I.data[vrc_pkg::ADDR_PRI_MSB:vrc_pkg::ADDR_PRI_LSB])))
    else $error("address write mishandled");
endmodule

// [test/vrc_host.sv]
// Purpose: Host model that issues word writes and word reads
// Assumes: Calls start 1 ns after a rising edge of clk_i
// Notes: An idle cycle follows each request so the strobe drops cleanly
`timescale 1ns/100ps
module vrc_host (
  // Bus side
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  input wire logic rvalid_i,
  output vrc_pkg::vrc_req_t req_o
);
  initial req_o = '0;
  // Word write, both data bytes in one request
  task automatic write_word(input logic [7:0] cmd, input logic [15:0] data);
    req_o = '{wr: 1'b1, rd: 1'b0, cmd: cmd, data: data};
    @(posedge clk_i);
    #1 req_o = '0;
    @(posedge clk_i);
    #1;
  endtask
  // Word read, answer taken in the cycle after the taking edge
  task automatic read_word(input logic [7:0] cmd, output logic [16:0] got);
    req_o = '{wr: 1'b0, rd: 1'b1, cmd: cmd, data: 16'h0000};
    @(posedge clk_i);
    #1 req_o = '0;
    got = {rvalid_i, rdata_i};
    @(posedge clk_i);
    #1;
  endtask
endmodule

// [test/vrc_config_bench.sv]
// Purpose: Self-checking bench of the options and bus address registers
// Assumes: Inputs move 1 ns after the rising edge
// Notes: The bench plays the NVM and the supply reset through RESTORE_I
`timescale 1ns/100ps
module vrc_config_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic restore = 1'b0;
  logic strap = 1'b1;
  logic pin_low = 1'b0;
  logic [6:0] nvm_addr = 7'h24;
  logic [15:0] nvm_opt = 16'h000a;
  logic [3:0] mant = 4'h8;
  logic [15:0] rdata;
  logic rvalid;
  logic [16:0] got;
  logic [2:0] ovth;
  logic oven, breq, bstart;
  logic [6:0] act, sto;
  vrc_pkg::vrc_req_t req;
  vrc_pkg::vrc_opt_t opt;
  int fails = 0;
  int samples_checked = 0;
  // 100 MHz clock
  always #5 clk = ~clk;
  vrc_config u_vrc_config (.CLK_I(clk), .RESET_I(rst), .CE_I(ce), .RESTORE_I(restore),
    .NVM_OPT_I(nvm_opt), .NVM_ADDR_I(nvm_addr), .DIVIDER_STRAP_I(strap), .REQ_I(req),
    .RDATA_O(rdata), .RVALID_O(rvalid), .ADDR_PIN_LOW_I(pin_low), .LOOP_MANT_I(mant),
    .OPT_O(opt), .OV_THRESH_O(ovth), .OV_FAULT_EN_O(oven), .BOOT_REQ_O(breq),
    .BOOT_START_O(bstart), .ACTIVE_ADDR_O(act), .STORED_ADDR_O(sto));
  vrc_host u_vrc_host (.clk_i(clk), .rdata_i(rdata), .rvalid_i(rvalid), .req_o(req));
  // *****************
  // Helpers
  // *****************
  task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Read with valid flag and data judged together
  task automatic rd(input logic [7:0] cmd, input logic [15:0] exp);
    u_vrc_host.read_word(cmd, got);
    chk("read word", {1'b1, exp}, got);
  endtask
  // One-cycle restore, as after a supply reset
  task automatic do_restore(input logic [6:0] a);
    nvm_addr = a;
    restore = 1'b1;
    tick(1);
    restore = 1'b0;
    tick(1);
  endtask
  task automatic end_of_test();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  // *****************
  // Scenarios
  // *****************
  task automatic test_restore();
    chk("active address at reset", 17'h0, 17'(act));
    do_restore(7'h24);
    chk("active address", 17'h24, 17'(act));
    rd(vrc_pkg::CMD_BUS_ADDR, 16'h2424);
    rd(vrc_pkg::CMD_OPTIONS, 16'h001a);
    $display("test_restore done");
  endtask
  task automatic test_options();
    u_vrc_host.write_word(vrc_pkg::CMD_OPTIONS, 16'hffe1);
    rd(vrc_pkg::CMD_OPTIONS, 16'h0011);
    chk("fault enable", 17'h0, 17'(oven));
    chk("threshold select", 17'h0, 17'(opt.rst_hi_sel));
    u_vrc_host.write_word(vrc_pkg::CMD_OPTIONS, 16'h0008);
    chk("fault enable", 17'h1, 17'(oven));
    chk("threshold select", 17'h1, 17'(opt.rst_hi_sel));
    // Strap high, threshold select high, all else low
    chk("option outputs", 17'h18, 17'(opt));
    $display("test_options done");
  endtask
  task automatic test_ov_table();
    logic [3:0] mants [4] = '{vrc_pkg::MANT_8, vrc_pkg::MANT_4, vrc_pkg::MANT_2,
      vrc_pkg::MANT_1};
    for (int s = 0; s < 2; s++) begin
      u_vrc_host.write_word(vrc_pkg::CMD_OPTIONS, 16'(s * 2));
      for (int m = 0; m < 4; m++) begin
        mant = mants[m];
        tick(2);
        chk("threshold index", 17'(s * 4 + m), 17'(ovth));
      end
    end
    // Any other mantissa falls back to the top index of the set
    mant = 4'h5;
    tick(2);
    chk("threshold index other", 17'h7, 17'(ovth));
    mant = vrc_pkg::MANT_8;
    $display("test_ov_table done");
  endtask
  task automatic test_reset_pin();
    pin_low = 1'b1;
    tick(4);
    chk("boot request disabled", 17'h0, 17'(breq));
    u_vrc_host.write_word(vrc_pkg::CMD_OPTIONS, 16'h0004);
    chk("boot start", 17'h1, 17'(bstart));
    chk("boot request", 17'h1, 17'(breq));
    tick(1);
    chk("boot start pulse", 17'h0, 17'(bstart));
    pin_low = 1'b0;
    tick(2);
    chk("boot request released", 17'h0, 17'(breq));
    pin_low = 1'b1;
    tick(2);
    chk("boot request on pin", 17'h1, 17'(breq));
    pin_low = 1'b0;
    $display("test_reset_pin done");
  endtask
  task automatic test_address();
    u_vrc_host.write_word(vrc_pkg::CMD_BUS_ADDR, 16'hffff);
    rd(vrc_pkg::CMD_BUS_ADDR, 16'h7f7f);
    chk("active address kept", 17'h24, 17'(act));
    // A write while the clock enable is low must leave no trace
    ce = 1'b0;
    u_vrc_host.write_word(vrc_pkg::CMD_BUS_ADDR, 16'h1200);
    ce = 1'b1;
    rd(vrc_pkg::CMD_BUS_ADDR, 16'h7f7f);
    u_vrc_host.write_word(vrc_pkg::CMD_STORE_ALL, 16'h0000);
    chk("stored address", 17'h7f, 17'(sto));
    chk("active before supply reset", 17'h24, 17'(act));
    do_restore(7'h7f);
    chk("active after supply reset", 17'h7f, 17'(act));
    rd(8'h00, 16'h0000);
    u_vrc_host.write_word(vrc_pkg::CMD_BUS_ADDR, 16'h1280);
    rd(vrc_pkg::CMD_BUS_ADDR, 16'h1212);
    $display("test_address done");
  endtask
  // Main sequence
  initial begin
    tick(6);
    rst = 1'b0;
    tick(1);
    test_restore();
    test_options();
    test_ov_table();
    test_reset_pin();
    test_address();
    end_of_test();
  end
  // Watchdog, far beyond the roughly 70 cycles the scenarios need
  initial begin
    #20000;
    fails++;
    end_of_test();
  end
endmodule
